// file: common/pbp_pkg.sv
// constants for the phy byte port and line pin block
package pbp_pkg;

  // ----------------------------------------------------------------
  // bus and data widths
  // ----------------------------------------------------------------
  localparam int AW     = 5;
  localparam int DW     = 32;
  localparam int BYTE_W = 8;
  localparam int NIB_W  = 4;
  localparam int LS_W   = 3;
  localparam int PAR_W  = BYTE_W + 2;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] OFS_LINE_CTRL_C   = 5'h00;
  localparam logic [AW-1:0] OFS_PHYS_STATUS_A = 5'h04;
  localparam logic [AW-1:0] OFS_LINE_STATUS_A = 5'h08;
  localparam logic [AW-1:0] OFS_EVENT         = 5'h0c;
  localparam logic [AW-1:0] OFS_TAP_DIAG      = 5'h10;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_CIPHER_BIT = 0;
  localparam int CTRL_TXOFF_BIT  = 1;
  localparam int PST_SD_INV_BIT  = 0;
  localparam int PST_BYPASS_BIT  = 1;
  localparam int PST_EBERR_BIT   = 2;
  localparam int LST_UNKN_BIT    = 3;
  localparam int EV_DETECT_BIT   = 0;
  localparam int EV_PARITY_BIT   = 1;
  localparam int DIAG_CTL_BIT    = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [BYTE_W-1:0] RX_IDLE_BYTE = 8'hff;
  localparam logic [DW-1:0]     ZERO_WORD    = 32'h0000_0000;

endpackage

// file: rtl/pbp_even_par.sv
// even parity bit generator over a vector
`timescale 1ns/1ps

module pbp_even_par #(
  parameter int W = 10
) (
  input  wire logic [W-1:0] i_bits, // bits covered by parity
  output wire logic         o_par   // one when the count of ones is odd
);

  // ----------------------------------------------------------------
  // reduction xor
  // ----------------------------------------------------------------
  // parity bit that makes the total count of ones even
  assign o_par = ^i_bits;

endmodule

// file: rtl/pbp_phy_port.sv
// mac side byte port to the phy, filter tap and line pins
// Function
// - upper receive flag marks control or data
// - lower receive flag marks control or data
// - receive parity makes eleven bits even
// - device drives eight bit transmit bus
// - upper transmit flag marks control nibble
// - lower transmit flag marks control nibble
// - transmit parity makes eleven bits even
// - upper receive nibble copied to filter tap
// - lower nibble tap; input side diagnostics
// - each tap nibble has a control flag
// - strap or cipher bit selects scrambling
// - transmitter off holds line at zero
// - inverted detect stored; rise sets event
// - line state field drives three pins
// - unknown line state bit drives pin
// - elasticity buffer error output on slips
// - encoder off input bypasses block coding
// - pins float only in test access
// - receive capture resets to all ones
`timescale 1ns/1ps

module pbp_phy_port
  import pbp_pkg::*;
(
  input  wire logic                        i_clk,                  // byte clock
  input  wire logic                        i_rst_n,                // async reset
  input  wire logic [pbp_pkg::AW-1:0]      i_avs_address,          // byte address
  input  wire logic                        i_avs_read,             // read request
  input  wire logic                        i_avs_write,            // write request
  input  wire logic [pbp_pkg::DW-1:0]      i_avs_writedata,        // write data
  input  wire logic [3:0]                  i_avs_byteenable,       // byte lanes
  output wire logic [pbp_pkg::DW-1:0]      o_avs_readdata,         // read data
  output wire logic                        o_avs_waitrequest,      // stall
  input  wire logic [pbp_pkg::BYTE_W-1:0]  i_recv_byte_bus,        // phy byte
  input  wire logic                        i_recv_upper_ctl_flag,  // upper ctl
  input  wire logic                        i_recv_lower_ctl_flag,  // lower ctl
  input  wire logic                        i_recv_parity_bit,      // even parity
  output wire logic [pbp_pkg::BYTE_W-1:0]  o_mac_rx_byte,          // to mac
  output wire logic                        o_mac_rx_upper_ctl,     // to mac
  output wire logic                        o_mac_rx_lower_ctl,     // to mac
  output wire logic [pbp_pkg::NIB_W-1:0]   o_filter_tap_upper,     // tap hi
  output wire logic                        o_filter_tap_upper_ctl, // tap hi ctl
  output wire logic [pbp_pkg::NIB_W-1:0]   o_filter_tap_lower,     // tap lo out
  output wire logic                        o_filter_tap_lower_oe,  // tap lo drive
  input  wire logic [pbp_pkg::NIB_W-1:0]   i_filter_tap_lower,     // tap lo in
  output wire logic                        o_filter_tap_lower_ctl, // lo ctl out
  output wire logic                        o_filter_tap_lower_ctl_oe, // drive
  input  wire logic                        i_filter_tap_lower_ctl, // lo ctl in
  input  wire logic [pbp_pkg::BYTE_W-1:0]  i_mac_tx_byte,          // from mac
  input  wire logic                        i_mac_tx_upper_ctl,     // from mac
  input  wire logic                        i_mac_tx_lower_ctl,     // from mac
  output wire logic [pbp_pkg::BYTE_W-1:0]  o_xmit_byte_bus,        // to phy
  output wire logic                        o_xmit_upper_ctl_flag,  // to phy
  output wire logic                        o_xmit_lower_ctl_flag,  // to phy
  output wire logic                        o_xmit_parity_bit,      // to phy
  input  wire logic                        i_line_tx_bit,          // nrzi bit
  output wire logic                        o_tx_p,                 // line +
  output wire logic                        o_tx_n,                 // line -
  output wire logic                        o_optical_tx_disable_n, // tx off
  input  wire logic                        i_signal_detect_in,     // detect
  input  wire logic                        i_scrambler_select_strap, // strap
  output wire logic                        o_scramble_en,          // copper
  input  wire logic [pbp_pkg::LS_W-1:0]    i_line_state,           // from core
  input  wire logic                        i_unknown_state,        // from core
  output wire logic [pbp_pkg::LS_W-1:0]    o_line_state_out,       // pins
  output wire logic                        o_unknown_state_out,    // pin
  input  wire logic                        i_eb_overflow,          // eb slip
  input  wire logic                        i_eb_underflow,         // eb slip
  output wire logic                        o_elastic_buf_error,    // eb error
  input  wire logic                        i_coder_bypass,         // encoder off
  output wire logic                        o_codec_enable,         // 4b5b on
  input  wire logic                        i_test_access           // tap active
);
  import pbp_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0] rx_byte_q;
  logic              rx_up_q;
  logic              rx_lo_q;
  logic              rx_par_q;
  logic              rx_live_q;
  logic              rx_calc;
  logic              rx_bad;
  logic [BYTE_W-1:0] tx_byte_q;
  logic              tx_up_q;
  logic              tx_lo_q;
  logic              tx_par_q;
  logic              tx_calc;
  logic              txp_q;
  logic              cipher_q;
  logic              tx_off_q;
  logic              strap_q;
  logic              scr_q;
  logic              sd_prev_q;
  logic              sd_inv_q;
  logic              sd_rise;
  logic              ev_det_q;
  logic              ev_par_q;
  logic [LS_W-1:0]   ls_q;
  logic              unkn_q;
  logic              eberr_q;
  logic              bypass_q;
  logic              ack_q;
  logic              req;
  logic              wr_go;
  logic              clr_det;
  logic              clr_par;
  logic [DW-1:0]     rdata_q;
  logic [DW-1:0]     rmux;

  // ----------------------------------------------------------------
  // receive capture
  // ----------------------------------------------------------------
  // idle value is all ones, as a pulled-up undriven bus reads
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_byte_q <= RX_IDLE_BYTE;
      rx_up_q   <= 1'b1;
      rx_lo_q   <= 1'b1;
      rx_par_q  <= 1'b1;
    end else begin
      rx_byte_q <= i_recv_byte_bus;
      rx_up_q   <= i_recv_upper_ctl_flag;
      rx_lo_q   <= i_recv_lower_ctl_flag;
      rx_par_q  <= i_recv_parity_bit;
    end
  end

  // checking waits one byte so reset idle values never count
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_live_q <= 1'b0;
    end else begin
      rx_live_q <= 1'b1;
    end
  end

  // parity over byte and both flags
  pbp_even_par #(
    .W (PAR_W)
  ) u_rx_par (
    .i_bits ({rx_byte_q, rx_up_q, rx_lo_q}),
    .o_par  (rx_calc)
  );

  assign rx_bad = rx_live_q && (rx_calc != rx_par_q);

  // internal receive bus and both filter taps share the capture flops
  assign o_mac_rx_byte          = rx_byte_q;
  assign o_mac_rx_upper_ctl     = rx_up_q;
  assign o_mac_rx_lower_ctl     = rx_lo_q;
  assign o_filter_tap_upper     = rx_byte_q[BYTE_W-1:NIB_W];
  assign o_filter_tap_upper_ctl = rx_up_q;
  assign o_filter_tap_lower     = rx_byte_q[NIB_W-1:0];
  assign o_filter_tap_lower_ctl = rx_lo_q;

  // tap pins float only while the test access port owns them
  assign o_filter_tap_lower_oe     = ~i_test_access;
  assign o_filter_tap_lower_ctl_oe = ~i_test_access;

  // ----------------------------------------------------------------
  // transmit drive
  // ----------------------------------------------------------------
  // parity is formed from the same inputs that load the bus flops
  pbp_even_par #(
    .W (PAR_W)
  ) u_tx_par (
    .i_bits ({i_mac_tx_byte, i_mac_tx_upper_ctl, i_mac_tx_lower_ctl}),
    .o_par  (tx_calc)
  );

  // byte, flags and parity leave together on one edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_byte_q <= '0;
      tx_up_q   <= 1'b0;
      tx_lo_q   <= 1'b0;
      tx_par_q  <= 1'b0;
    end else begin
      tx_byte_q <= i_mac_tx_byte;
      tx_up_q   <= i_mac_tx_upper_ctl;
      tx_lo_q   <= i_mac_tx_lower_ctl;
      tx_par_q  <= tx_calc;
    end
  end

  assign o_xmit_byte_bus       = tx_byte_q;
  assign o_xmit_upper_ctl_flag = tx_up_q;
  assign o_xmit_lower_ctl_flag = tx_lo_q;
  assign o_xmit_parity_bit     = tx_par_q;

  // ----------------------------------------------------------------
  // line side pins
  // ----------------------------------------------------------------
  // forced zero keeps the optical transmitter dark
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      txp_q <= 1'b0;
    end else begin
      txp_q <= tx_off_q ? 1'b0 : i_line_tx_bit;
    end
  end

  assign o_tx_p                 = txp_q;
  assign o_tx_n                 = ~txp_q;
  assign o_optical_tx_disable_n = ~tx_off_q;

  // strap is static, so plain sampling after release is enough
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      strap_q <= 1'b0;
      scr_q   <= 1'b0;
    end else begin
      strap_q <= i_scrambler_select_strap;
      scr_q   <= strap_q | cipher_q;
    end
  end

  assign o_scramble_en = scr_q;

  // signal detect status and rising edge
  assign sd_rise = i_signal_detect_in & ~sd_prev_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sd_prev_q <= 1'b0;
      sd_inv_q  <= 1'b1;
    end else begin
      sd_prev_q <= i_signal_detect_in;
      sd_inv_q  <= ~i_signal_detect_in;
    end
  end

  // line state, unknown state, slip and bypass mirrors
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ls_q     <= '0;
      unkn_q   <= 1'b0;
      eberr_q  <= 1'b0;
      bypass_q <= 1'b0;
    end else begin
      ls_q     <= i_line_state;
      unkn_q   <= i_unknown_state;
      eberr_q  <= i_eb_overflow | i_eb_underflow;
      bypass_q <= i_coder_bypass;
    end
  end

  assign o_line_state_out    = ls_q;
  assign o_unknown_state_out = unkn_q;
  assign o_elastic_buf_error = eberr_q;
  assign o_codec_enable      = ~bypass_q;

  // ----------------------------------------------------------------
  // avalon slave, one wait state on every access
  // ----------------------------------------------------------------
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack_q;
  assign wr_go             = i_avs_write & ack_q & i_avs_byteenable[0];
  assign clr_det = wr_go && (i_avs_address == OFS_EVENT)
                   && i_avs_writedata[EV_DETECT_BIT];
  assign clr_par = wr_go && (i_avs_address == OFS_EVENT)
                   && i_avs_writedata[EV_PARITY_BIT];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // control register writes
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cipher_q <= 1'b0;
      tx_off_q <= 1'b0;
    end else if (wr_go && (i_avs_address == OFS_LINE_CTRL_C)) begin
      cipher_q <= i_avs_writedata[CTRL_CIPHER_BIT];
      tx_off_q <= i_avs_writedata[CTRL_TXOFF_BIT];
    end
  end

  // sticky events: a new event beats a clear in the same cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ev_det_q <= 1'b0;
      ev_par_q <= 1'b0;
    end else begin
      ev_det_q <= sd_rise | (ev_det_q & ~clr_det);
      ev_par_q <= rx_bad | (ev_par_q & ~clr_par);
    end
  end

  // read multiplexer; unmapped addresses read zero
  always_comb begin
    rmux = ZERO_WORD;
    unique case (i_avs_address)
      OFS_LINE_CTRL_C: begin
        rmux[CTRL_CIPHER_BIT] = strap_q | cipher_q;
        rmux[CTRL_TXOFF_BIT]  = tx_off_q;
      end
      OFS_PHYS_STATUS_A: begin
        rmux[PST_SD_INV_BIT] = sd_inv_q;
        rmux[PST_BYPASS_BIT] = bypass_q;
        rmux[PST_EBERR_BIT]  = eberr_q;
      end
      OFS_LINE_STATUS_A: begin
        rmux[LS_W-1:0]    = ls_q;
        rmux[LST_UNKN_BIT] = unkn_q;
      end
      OFS_EVENT: begin
        rmux[EV_DETECT_BIT] = ev_det_q;
        rmux[EV_PARITY_BIT] = ev_par_q;
      end
      OFS_TAP_DIAG: begin
        rmux[NIB_W-1:0]   = i_filter_tap_lower;
        rmux[DIAG_CTL_BIT] = i_filter_tap_lower_ctl;
      end
      default: begin
        rmux = ZERO_WORD;
      end
    endcase
  end

  // data is latched in the wait cycle and stands at the answer edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= ZERO_WORD;
    end else if (i_avs_read && !ack_q) begin
      rdata_q <= rmux;
    end
  end

  assign o_avs_readdata = rdata_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_rx_odd;
    rx_live_q ##0 (^{rx_byte_q, rx_up_q, rx_lo_q, rx_par_q});
  endsequence

  sequence s_sd_up;
    !i_signal_detect_in ##1 i_signal_detect_in;
  endsequence

  a_tx_par_even: assert property (
    ^{o_xmit_byte_bus, o_xmit_upper_ctl_flag, o_xmit_lower_ctl_flag,
      o_xmit_parity_bit} == 1'b0)
    else $error("transmit parity not even");

  a_tx_flag_follow: assert property (
    ##1 (o_xmit_upper_ctl_flag == $past(i_mac_tx_upper_ctl))
    && (o_xmit_lower_ctl_flag == $past(i_mac_tx_lower_ctl))
    && (o_xmit_byte_bus == $past(i_mac_tx_byte)))
    else $error("transmit bus lost mac byte");

  a_rx_par_flag: assert property (
    s_rx_odd |=> ev_par_q)
    else $error("parity mismatch not flagged");

  a_tap_copy: assert property (
    ##1 (o_filter_tap_upper == $past(i_recv_byte_bus[BYTE_W-1:NIB_W]))
    && (o_filter_tap_lower_ctl == $past(i_recv_lower_ctl_flag)))
    else $error("filter tap not tracking receive bus");

  a_scramble_sel: assert property (
    ##2 o_scramble_en == ($past(i_scrambler_select_strap, 2)
                          | $past(cipher_q)))
    else $error("scramble select wrong");

  a_tx_dark: assert property (
    tx_off_q |-> !o_optical_tx_disable_n ##1 (!o_tx_p && o_tx_n))
    else $error("line not held at zero while off");

  a_sd_event: assert property (
    s_sd_up |=> ev_det_q && sd_inv_q == 1'b0)
    else $error("detect rise not recorded");

  a_line_pins: assert property (
    ##1 (o_line_state_out == $past(i_line_state))
    && (o_unknown_state_out == $past(i_unknown_state)))
    else $error("line state pins stale");

  a_eb_error: assert property (
    (i_eb_overflow || i_eb_underflow) |=> o_elastic_buf_error)
    else $error("slip not reported");

  a_bypass_codec: assert property (
    i_coder_bypass |=> !o_codec_enable)
    else $error("codec not bypassed");

  a_tap_float: assert property (
    !i_test_access |-> o_filter_tap_lower_oe && o_filter_tap_lower_ctl_oe)
    else $error("tap pin floating in function mode");

  a_bus_answer: assert property (
    (req && !ack_q) |=> (!o_avs_waitrequest || !req))
    else $error("bus answer late");

endmodule

// file: bench/pbp_phy_model.sv
// partner model of the external phy feeding the receive byte bus
`timescale 1ns/1ps

module pbp_phy_model (
  input  wire logic       i_clk,     // byte clock
  input  wire logic       i_rst_n,   // async reset, active low
  input  wire logic       i_bad_par, // corrupt parity of the next byte
  output logic      [7:0] o_byte,    // receive byte
  output logic            o_upper,   // upper nibble control flag
  output logic            o_lower,   // lower nibble control flag
  output logic            o_par      // even parity over byte and flags
);
  logic [7:0] cnt_q;
  logic [7:0] nxt_byte;
  logic       nxt_up;
  logic       nxt_lo;

  // ----------------------------------------------------------------
  // byte stream
  // ----------------------------------------------------------------
  // flags walk through all four combinations across the stream
  assign nxt_byte = cnt_q ^ 8'ha5;
  assign nxt_up   = cnt_q[2];
  assign nxt_lo   = cnt_q[1] ^ cnt_q[3];

  // outside the async reset, everything moves on the byte clock edge only, never between edges
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q   <= 8'h00;
      o_byte  <= 8'hff; // lines idle at the pull-up level
      o_upper <= 1'b1;
      o_lower <= 1'b1;
      o_par   <= 1'b0;  // ten ones already even
    end else begin
      cnt_q   <= cnt_q + 8'h01;
      o_byte  <= nxt_byte;
      o_upper <= nxt_up;
      o_lower <= nxt_lo;
      o_par   <= (^{nxt_byte, nxt_up, nxt_lo}) ^ i_bad_par;
    end
  end
endmodule

// file: bench/tb_top.sv
// self-checking bench for the phy byte port and line pin block
`timescale 1ns/1ps

module tb_top;
  import pbp_pkg::*;
  logic              i_clk, i_rst_n, i_avs_read, i_avs_write, o_avs_waitrequest;
  logic [AW-1:0]     i_avs_address;
  logic [DW-1:0]     i_avs_writedata, o_avs_readdata;
  logic [3:0]        i_avs_byteenable;
  logic [BYTE_W-1:0] i_recv_byte_bus, o_mac_rx_byte, i_mac_tx_byte, o_xmit_byte_bus;
  logic [NIB_W-1:0]  o_filter_tap_upper, o_filter_tap_lower, i_filter_tap_lower;
  logic [LS_W-1:0]   i_line_state, o_line_state_out;
  logic i_recv_upper_ctl_flag, i_recv_lower_ctl_flag, i_recv_parity_bit, o_mac_rx_upper_ctl;
  logic o_mac_rx_lower_ctl, o_filter_tap_upper_ctl, o_filter_tap_lower_oe;
  logic i_filter_tap_lower_ctl, o_filter_tap_lower_ctl, o_filter_tap_lower_ctl_oe;
  logic i_mac_tx_upper_ctl, i_mac_tx_lower_ctl, o_xmit_upper_ctl_flag, o_xmit_lower_ctl_flag;
  logic o_xmit_parity_bit, i_line_tx_bit, o_tx_p, o_tx_n, o_optical_tx_disable_n;
  logic i_signal_detect_in, i_scrambler_select_strap, o_scramble_en, i_unknown_state;
  logic o_unknown_state_out, i_eb_overflow, i_eb_underflow, o_elastic_buf_error;
  logic i_coder_bypass, o_codec_enable, i_test_access, bad_par;
  logic [7:0]        v, pb;
  logic              pu, pl;
  logic [DW-1:0]     q;
  int                num_errors, check_count;

  pbp_phy_port dut_u (
    .i_clk, .i_rst_n, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_recv_byte_bus,
    .i_recv_upper_ctl_flag, .i_recv_lower_ctl_flag, .i_recv_parity_bit, .o_mac_rx_byte,
    .o_mac_rx_upper_ctl, .o_mac_rx_lower_ctl, .o_filter_tap_upper, .o_filter_tap_upper_ctl,
    .o_filter_tap_lower, .o_filter_tap_lower_oe, .i_filter_tap_lower, .o_filter_tap_lower_ctl,
    .o_filter_tap_lower_ctl_oe, .i_filter_tap_lower_ctl, .i_mac_tx_byte, .i_mac_tx_upper_ctl,
    .i_mac_tx_lower_ctl, .o_xmit_byte_bus, .o_xmit_upper_ctl_flag, .o_xmit_lower_ctl_flag,
    .o_xmit_parity_bit, .i_line_tx_bit, .o_tx_p, .o_tx_n, .o_optical_tx_disable_n,
    .i_signal_detect_in, .i_scrambler_select_strap, .o_scramble_en, .i_line_state,
    .i_unknown_state, .o_line_state_out, .o_unknown_state_out, .i_eb_overflow,
    .i_eb_underflow, .o_elastic_buf_error, .i_coder_bypass, .o_codec_enable, .i_test_access
  );

  pbp_phy_model phy_u (
    .i_clk, .i_rst_n, .i_bad_par(bad_par), .o_byte(i_recv_byte_bus),
    .o_upper(i_recv_upper_ctl_flag), .o_lower(i_recv_lower_ctl_flag), .o_par(i_recv_parity_bit)
  );

  // ----------------------------------------------------------------
  // clock, checking and bus tasks
  // ----------------------------------------------------------------
  // 200 MHz byte clock; symbol and memory clocks live outside
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge; completes there
  task automatic acc(logic w, logic [AW-1:0] a, logic [DW-1:0] d, output logic [DW-1:0] r);
    int n;
    @(posedge i_clk);
    i_avs_address   <= a;
    i_avs_write     <= w;
    i_avs_read      <= ~w;
    i_avs_writedata <= d;
    n = 0;
    r = '0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 64);
    if (o_avs_waitrequest !== 1'b0) begin
      num_errors++;
      $display("unexpected waitrequest stuck at %h", a);
      stop_test();
    end else begin
      r = o_avs_readdata;
      i_avs_read  <= 1'b0;
      i_avs_write <= 1'b0;
    end
  endtask

  task automatic wr(logic [AW-1:0] a, logic [DW-1:0] d);
    logic [DW-1:0] r;
    acc(1'b1, a, d, r);
  endtask

  task automatic rd_chk(string nm, logic [AW-1:0] a, logic [DW-1:0] e);
    acc(1'b0, a, '0, q);
    chk(nm, q, e);
  endtask

  task automatic settle(int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  // a hang anywhere counts as a failure
  initial begin
    #400us;
    num_errors++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {i_rst_n, i_avs_read, i_avs_write, i_avs_address, i_avs_writedata, bad_par} = '0;
    {i_mac_tx_byte, i_mac_tx_upper_ctl, i_mac_tx_lower_ctl, i_signal_detect_in} = '0;
    {i_scrambler_select_strap, i_line_state, i_unknown_state, i_test_access} = '0;
    {i_eb_overflow, i_eb_underflow, i_coder_bypass} = '0;
    i_avs_byteenable       = 4'hf;
    i_line_tx_bit          = 1'b1;
    i_filter_tap_lower     = 4'ha;
    i_filter_tap_lower_ctl = 1'b1;
    num_errors             = 0;
    check_count            = 0;
    repeat (10) @(posedge i_clk);
    chk("rx_idle", o_mac_rx_byte, 8'hff);
    i_rst_n <= 1'b1;
    rd_chk("ctrl_rst", OFS_LINE_CTRL_C, '0);
    rd_chk("phys_rst", OFS_PHYS_STATUS_A, 32'h1);
    rd_chk("event_rst", OFS_EVENT, '0);
    rd_chk("tap_diag", OFS_TAP_DIAG, 32'h1a);
    wr(5'h14, 32'h3);
    rd_chk("unmapped", 5'h14, '0);
    i_avs_byteenable <= 4'h0;
    wr(OFS_LINE_CTRL_C, 32'h3);
    i_avs_byteenable <= 4'hf;
    rd_chk("ctrl_be", OFS_LINE_CTRL_C, '0);
    // receive stream through to mac side and filter taps
    for (int i = 0; i < 12; i++) begin
      @(negedge i_clk);
      {pu, pl, pb} = {i_recv_upper_ctl_flag, i_recv_lower_ctl_flag, i_recv_byte_bus};
      @(negedge i_clk);
      chk("mac_rx", {o_mac_rx_upper_ctl, o_mac_rx_lower_ctl, o_mac_rx_byte}, {pu, pl, pb});
      chk("tap", {o_filter_tap_upper_ctl, o_filter_tap_upper, o_filter_tap_lower_ctl,
                  o_filter_tap_lower}, {pu, pb[7:4], pl, pb[3:0]});
      chk("tap_oe", {o_filter_tap_lower_oe, o_filter_tap_lower_ctl_oe}, 2'b11);
    end
    rd_chk("par_clean", OFS_EVENT, '0);
    @(posedge i_clk);
    bad_par <= 1'b1;
    @(posedge i_clk);
    bad_par <= 1'b0;
    settle(3);
    rd_chk("par_event", OFS_EVENT, 32'h2);
    wr(OFS_EVENT, 32'h2);
    rd_chk("par_clear", OFS_EVENT, '0);
    // transmit path with every flag combination
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk);
      v = 8'(i * 8'h29 + 8'h07);
      i_mac_tx_byte      <= v;
      i_mac_tx_upper_ctl <= i[1];
      i_mac_tx_lower_ctl <= i[0];
      settle(1);
      chk("xmit", {o_xmit_upper_ctl_flag, o_xmit_lower_ctl_flag, o_xmit_byte_bus},
          {i[1], i[0], v});
      chk("xmit_parity_bit", o_xmit_parity_bit, ^{v, i[1:0]});
    end
    // line status pins follow the core
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clk);
      i_line_state    <= i[2:0];
      i_unknown_state <= ~i[0];
      i_eb_overflow   <= i[0] & i[1];
      i_eb_underflow  <= i[2] & ~i[0];
      i_coder_bypass  <= i[1];
      settle(1);
      chk("line", {o_unknown_state_out, o_line_state_out}, {~i[0], i[2:0]});
      chk("eb_err", o_elastic_buf_error, (i[0] & i[1]) | (i[2] & ~i[0]));
      chk("codec", o_codec_enable, !i[1]);
    end
    rd_chk("line_reg", OFS_LINE_STATUS_A, 32'h7);
    {i_line_state, i_eb_overflow, i_coder_bypass} <= '0;
    // scrambling from the control bit, then from the strap alone
    wr(OFS_LINE_CTRL_C, 32'h1);
    rd_chk("cipher", OFS_LINE_CTRL_C, 32'h1);
    chk("scr_bit", o_scramble_en, 1'b1);
    wr(OFS_LINE_CTRL_C, 32'h0);
    i_scrambler_select_strap <= 1'b1;
    settle(3);
    rd_chk("strap", OFS_LINE_CTRL_C, 32'h1);
    chk("scr_strap", o_scramble_en, 1'b1);
    i_scrambler_select_strap <= 1'b0;
    // transmitter off forces the line to zero
    wr(OFS_LINE_CTRL_C, 32'h2);
    settle(2);
    chk("tx_off", {o_optical_tx_disable_n, o_tx_p, o_tx_n}, 3'b001);
    chk("scr_off", o_scramble_en, 1'b0);
    wr(OFS_LINE_CTRL_C, 32'h0);
    settle(2);
    chk("tx_on", {o_optical_tx_disable_n, o_tx_p, o_tx_n}, 3'b110);
    // signal detect rise
    @(posedge i_clk);
    i_signal_detect_in <= 1'b1;
    settle(2);
    rd_chk("sd_event", OFS_EVENT, 32'h1);
    rd_chk("sd_status", OFS_PHYS_STATUS_A, '0);
    wr(OFS_EVENT, 32'h1);
    rd_chk("sd_clear", OFS_EVENT, '0);
    // test access floats the lower tap pins
    i_test_access <= 1'b1;
    @(negedge i_clk);
    chk("tap_float", {o_filter_tap_lower_oe, o_filter_tap_lower_ctl_oe}, 2'b00);
    stop_test();
  end
endmodule
